// file: src/flash_host.sv
// Host-side sequencer for erase, suspend, status, identification and query.
`timescale 1ns/1ns
module flash_host #(
	parameter longint TIMEOUT_CYC = flash_host_pkg::TIMEOUT_CYC_DEF,
	parameter int ERES_CYC = flash_host_pkg::ERES_CYC,
	parameter int SUSP_CYC = flash_host_pkg::ES_CYC
) (
	input  wire logic                              mclk,
	input  wire logic                              rst,
	input  wire logic                              op_valid,
	output logic                                   op_ready,
	input  wire flash_host_pkg::op_t               op_code,
	input  wire logic [flash_host_pkg::ADDR_W-1:0] op_addr,
	input  wire logic                              byte_mode,
	output logic                                   res_valid,
	output logic [flash_host_pkg::DATA_W-1:0]      res_data,
	output logic                                   res_timeout,
	output logic                                   ce_n,
	output logic                                   oe_n,
	output logic                                   we_n,
	output logic [flash_host_pkg::ADDR_W-1:0]      flash_addr,
	output logic [flash_host_pkg::DATA_W-1:0]      dq_o,
	output logic                                   dq_oe,
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i
);
	typedef enum logic [2:0]
	{
		S_IDLE = 3'b000,
		S_CMD = 3'b001,
		S_READ = 3'b010,
		S_POLL = 3'b011,
		S_EXIT = 3'b100,
		S_WAIT = 3'b101,
		S_DONE = 3'b110
	} state_t;

	flash_cycle_if cyc ();
	flash_bus_cycle u_cycle (
		.mclk  (mclk),
		.rst   (rst),
		.cyc   (cyc),
		.ce_n  (ce_n),
		.oe_n  (oe_n),
		.we_n  (we_n),
		.addr  (flash_addr),
		.dq_o  (dq_o),
		.dq_oe (dq_oe),
		.dq_i  (dq_i)
	);

	state_t state_q, state_d;
	flash_host_pkg::op_t op_q, op_d;
	logic [flash_host_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [2:0] step_q, step_d;
	logic [39:0] tmr_q, tmr_d;
	logic [31:0] eres_q, eres_d;
	logic first_q, first_d, tog_q, tog_d, issued_q, issued_d, tout_q, tout_d;
	logic [flash_host_pkg::DATA_W-1:0] data_q, data_d;
	logic [2:0] nsteps;
	logic [11:0] cmd_a;
	logic [7:0] cmd_d;

	// Command table: erase is unlock pair, setup, unlock pair, final byte; ID entry is unlock pair, 90; query, suspend and resume one write.
	always_comb
	begin
		cmd_a = flash_host_pkg::ADDR_555;
		cmd_d = flash_host_pkg::CMD_AA;
		nsteps = 3'h6;
		case (op_q)
			flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE:
			begin
				case (step_q)
					3'h0: cmd_d = flash_host_pkg::CMD_AA;
					3'h1:
					begin
						cmd_a = flash_host_pkg::ADDR_2AA;
						cmd_d = flash_host_pkg::CMD_55;
					end
					3'h2: cmd_d = flash_host_pkg::CMD_80;
					3'h3: cmd_d = flash_host_pkg::CMD_AA;
					3'h4:
					begin
						cmd_a = flash_host_pkg::ADDR_2AA;
						cmd_d = flash_host_pkg::CMD_55;
					end
					default:
					begin
						if (op_q == flash_host_pkg::OP_CHIP_ERASE)
							cmd_d = flash_host_pkg::CMD_CHIP_ERASE;
						else
						begin
							cmd_a = addr_q[11:0];
							cmd_d = flash_host_pkg::CMD_SECTOR_ERASE;
						end
					end
				endcase
			end
			flash_host_pkg::OP_ID_READ:
			begin
				nsteps = 3'h3;
				case (step_q)
					3'h1:
					begin
						cmd_a = flash_host_pkg::ADDR_2AA;
						cmd_d = flash_host_pkg::CMD_55;
					end
					3'h2: cmd_d = flash_host_pkg::CMD_ID_ENTRY;
					default: cmd_d = flash_host_pkg::CMD_AA;
				endcase
			end
			flash_host_pkg::OP_QUERY_READ:
			begin
				nsteps = 3'h1;
				cmd_a = flash_host_pkg::ADDR_QUERY;
				cmd_d = flash_host_pkg::CMD_QUERY;
			end
			flash_host_pkg::OP_SUSPEND:
			begin
				nsteps = 3'h1;
				cmd_d = flash_host_pkg::CMD_SUSPEND;
			end
			flash_host_pkg::OP_RESUME:
			begin
				nsteps = 3'h1;
				cmd_d = flash_host_pkg::CMD_RESUME;
			end
			default: nsteps = 3'h0;
		endcase
	end

	always_comb
	begin
		state_d = state_q;
		op_d = op_q;
		addr_d = addr_q;
		step_d = step_q;
		tmr_d = tmr_q;
		eres_d = (eres_q != 32'h0) ? eres_q - 32'h1 : eres_q;
		first_d = first_q;
		tog_d = tog_q;
		issued_d = 1'b0;
		tout_d = tout_q;
		data_d = data_q;
		cyc.req = 1'b0;
		cyc.wr = 1'b1;
		cyc.addr = {{(flash_host_pkg::ADDR_W-12){1'b0}}, cmd_a};
		cyc.wdata = {8'h00, cmd_d};
		case (state_q)
			S_IDLE:
			begin
				// Suspend is held back until the resume spacing has run out.
				if (op_valid && !(op_code == flash_host_pkg::OP_SUSPEND && eres_q != 32'h0))
				begin
					op_d = op_code;
					// Query offsets double in byte addressing.
					addr_d = (byte_mode && op_code == flash_host_pkg::OP_QUERY_READ) ?
						{op_addr[flash_host_pkg::ADDR_W-2:0], 1'b0} : op_addr;
					step_d = 3'h0;
					tout_d = 1'b0;
					state_d = (op_code == flash_host_pkg::OP_READ) ? S_READ : S_CMD;
				end
			end
			S_CMD:
			begin
				cyc.req = !issued_q;
				// The sector erase write carries the full sector address.
				if (op_q == flash_host_pkg::OP_SECTOR_ERASE && step_q == 3'h5)
					cyc.addr = addr_q;
				issued_d = !cyc.done && (issued_q || cyc.req);
				if (cyc.done)
				begin
					step_d = step_q + 3'h1;
					if (step_q + 3'h1 == nsteps)
					begin
						first_d = 1'b1;
						tmr_d = 40'h0;
						case (op_q)
							flash_host_pkg::OP_CHIP_ERASE, flash_host_pkg::OP_SECTOR_ERASE:
								state_d = S_POLL;
							flash_host_pkg::OP_SUSPEND: state_d = S_WAIT;
							flash_host_pkg::OP_RESUME:
							begin
								eres_d = 32'(ERES_CYC);
								state_d = S_DONE;
							end
							default: state_d = S_READ;
						endcase
					end
				end
			end
			S_READ:
			begin
				cyc.req = !issued_q;
				cyc.wr = 1'b0;
				cyc.addr = addr_q;
				issued_d = !cyc.done && (issued_q || cyc.req);
				if (cyc.done)
				begin
					data_d = cyc.rdata;
					// Leave identification or query mode so the array reads again.
					state_d = (op_q == flash_host_pkg::OP_READ) ? S_DONE : S_EXIT;
				end
			end
			S_EXIT:
			begin
				cyc.req = !issued_q;
				cyc.wdata = {8'h00, flash_host_pkg::CMD_ID_EXIT};
				issued_d = !cyc.done && (issued_q || cyc.req);
				if (cyc.done)
					state_d = S_DONE;
			end
			S_POLL:
			begin
				// Repeated OE reads at one address; done when the toggle line holds still.
				cyc.req = !issued_q;
				cyc.wr = 1'b0;
				cyc.addr = addr_q;
				issued_d = !cyc.done && (issued_q || cyc.req);
				tmr_d = tmr_q + 40'h1;
				if (cyc.done)
				begin
					first_d = 1'b0;
					tog_d = cyc.rdata[flash_host_pkg::TOGGLE_BIT];
					data_d = cyc.rdata;
					if (!first_q && tog_q == cyc.rdata[flash_host_pkg::TOGGLE_BIT])
						state_d = S_DONE;
				end
				if (tmr_q >= 40'(TIMEOUT_CYC) && !issued_q)
				begin
					// No new read may start once the wait is abandoned.
					cyc.req = 1'b0;
					issued_d = 1'b0;
					tout_d = 1'b1;
					state_d = S_DONE;
				end
			end
			S_WAIT:
			begin
				tmr_d = tmr_q + 40'h1;
				if (tmr_q >= 40'(SUSP_CYC))
					state_d = S_DONE;
			end
			S_DONE: state_d = S_IDLE;
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= S_IDLE;
			op_q <= flash_host_pkg::OP_READ;
			addr_q <= '0;
			step_q <= 3'h0;
			tmr_q <= 40'h0;
			eres_q <= 32'h0;
			first_q <= 1'b1;
			tog_q <= 1'b0;
			issued_q <= 1'b0;
			tout_q <= 1'b0;
			data_q <= '0;
		end
		else
		begin
			state_q <= state_d;
			op_q <= op_d;
			addr_q <= addr_d;
			step_q <= step_d;
			tmr_q <= tmr_d;
			eres_q <= eres_d;
			first_q <= first_d;
			tog_q <= tog_d;
			issued_q <= issued_d;
			tout_q <= tout_d;
			data_q <= data_d;
		end
	end

	assign op_ready = state_q == S_IDLE &&
		!(op_code == flash_host_pkg::OP_SUSPEND && eres_q != 32'h0);
	assign res_valid = state_q == S_DONE;
	assign res_data = data_q;
	assign res_timeout = tout_q;

	sequence s_final_write;
		!we_n && !ce_n;
	endsequence
	property p_chip_final;
		@(posedge mclk) disable iff (rst)
		(state_q == S_CMD && op_q == flash_host_pkg::OP_CHIP_ERASE && step_q == 3'h5) and s_final_write
		|-> flash_addr[11:0] == flash_host_pkg::ADDR_555 && dq_o[7:0] == flash_host_pkg::CMD_CHIP_ERASE;
	endproperty
	a_chip_final: assert property (p_chip_final) else $error("chip erase final write wrong");
	property p_sector_final;
		@(posedge mclk) disable iff (rst)
		(state_q == S_CMD && op_q == flash_host_pkg::OP_SECTOR_ERASE && step_q == 3'h5) and s_final_write
		|-> flash_addr == addr_q && dq_o[7:0] == flash_host_pkg::CMD_SECTOR_ERASE;
	endproperty
	a_sector_final: assert property (p_sector_final) else $error("sector erase final write wrong");
	property p_poll_addr;
		@(posedge mclk) disable iff (rst)
		(state_q == S_POLL && !ce_n) |-> flash_addr == addr_q && $stable(addr_q);
	endproperty
	a_poll_addr: assert property (p_poll_addr) else $error("status address moved");
	property p_no_early_suspend;
		@(posedge mclk) disable iff (rst)
		(!we_n && !ce_n && dq_o[7:0] == flash_host_pkg::CMD_SUSPEND) |-> eres_q == 32'h0;
	endproperty
	a_no_early_suspend: assert property (p_no_early_suspend) else $error("suspend too early");
	property p_cmd_upper_zero;
		@(posedge mclk) disable iff (rst)
		(state_q == S_CMD && !we_n && !(op_q == flash_host_pkg::OP_SECTOR_ERASE && step_q == 3'h5))
		|-> flash_addr[flash_host_pkg::ADDR_W-1:12] == '0 && dq_o[15:8] == 8'h00;
	endproperty
	a_cmd_upper_zero: assert property (p_cmd_upper_zero) else $error("command upper bits set");
	property p_id_exit;
		@(posedge mclk) disable iff (rst)
		(state_q == S_READ && op_q != flash_host_pkg::OP_READ && cyc.done) |=> state_q == S_EXIT;
	endproperty
	a_id_exit: assert property (p_id_exit) else $error("no exit after id read");
	property p_poll_done;
		@(posedge mclk) disable iff (rst)
		(state_q == S_POLL && cyc.done && !first_q && tog_q == cyc.rdata[6]) |=> res_valid;
	endproperty
	a_poll_done: assert property (p_poll_done) else $error("stable toggle not finished");
	property p_poll_reads;
		@(posedge mclk) disable iff (rst)
		(state_q == S_POLL && !ce_n) |-> !oe_n && we_n;
	endproperty
	a_poll_reads: assert property (p_poll_reads) else $error("poll not an OE read");
endmodule

// file: src/flash_host_pkg.sv
// Constants shared by the NOR flash host controller.
package flash_host_pkg;
	localparam int ADDR_W = 20;
	localparam int DATA_W = 16;
	localparam int CLK_MHZ = 100;
	// Command addresses and data (low 12 address bits, low data byte decoded).
	localparam logic [11:0] ADDR_555 = 12'h555;
	localparam logic [11:0] ADDR_2AA = 12'h2aa;
	localparam logic [7:0] CMD_AA = 8'haa;
	localparam logic [7:0] CMD_55 = 8'h55;
	localparam logic [7:0] CMD_80 = 8'h80;
	localparam logic [7:0] CMD_CHIP_ERASE = 8'h10;
	localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
	localparam logic [7:0] CMD_ID_ENTRY = 8'h90;
	localparam logic [7:0] CMD_ID_EXIT = 8'hf0;
	localparam logic [7:0] CMD_QUERY = 8'h98;
	localparam logic [7:0] CMD_SUSPEND = 8'hb0;
	localparam logic [7:0] CMD_RESUME = 8'hd0;
	localparam logic [11:0] ADDR_QUERY = 12'h055;
	// Identification and query addresses.
	localparam logic [ADDR_W-1:0] ID_MFR_ADDR = 20'h00000;
	localparam logic [ADDR_W-1:0] ID_DEV_ADDR = 20'h00001;
	localparam logic [ADDR_W-1:0] ID_ADD_ADDR = 20'h00003;
	localparam logic [ADDR_W-1:0] QRY_FIRST = 20'h00010;
	localparam int TOGGLE_BIT = 6;
	// Bus cycle timing in clock cycles (70 ns cycle, 25 ns pulses, 50 ns OE high).
	localparam int T_WP_NS = 25;
	localparam int T_RC_NS = 70;
	localparam int T_OEHP_NS = 50;
	localparam int WP_CYC = (T_WP_NS * CLK_MHZ + 999) / 1000;
	localparam int RC_CYC = (T_RC_NS * CLK_MHZ + 999) / 1000;
	localparam int OEHP_CYC = (T_OEHP_NS * CLK_MHZ + 999) / 1000;
	// Suspend latency and resume spacing.
	localparam int T_ES_US = 15;
	localparam int T_PS_US = 10;
	localparam int T_ERES_US = 500;
	localparam int ES_CYC = T_ES_US * CLK_MHZ;
	localparam int PS_CYC = T_PS_US * CLK_MHZ;
	localparam int ERES_CYC = T_ERES_US * CLK_MHZ;
	// Longest erase waits, in milliseconds.
	localparam int T_CHIP_MS = 16000;
	localparam int T_SEC_MAX_MS = 6000;
	localparam int TIMEOUT_MS = T_CHIP_MS * 4;
	// Sixty-four seconds of cycles overflows a 32-bit int, so the product is taken in 64 bits.
	localparam longint TIMEOUT_CYC_DEF = longint'(TIMEOUT_MS) * 1000 * CLK_MHZ;
	typedef enum logic [2:0]
	{
		OP_CHIP_ERASE = 3'h0,
		OP_SECTOR_ERASE = 3'h1,
		OP_READ = 3'h2,
		OP_ID_READ = 3'h3,
		OP_QUERY_READ = 3'h4,
		OP_SUSPEND = 3'h5,
		OP_RESUME = 3'h6
	} op_t;
endpackage

// file: src/flash_cycle_if.sv
// Handshake between the sequencer and the bus cycle engine.
`timescale 1ns/1ns
interface flash_cycle_if;
	logic                                   req;
	logic                                   wr;
	logic [flash_host_pkg::ADDR_W-1:0]      addr;
	logic [flash_host_pkg::DATA_W-1:0]      wdata;
	logic                                   done;
	logic [flash_host_pkg::DATA_W-1:0]      rdata;
	modport seq (output req, output wr, output addr, output wdata, input done, input rdata);
	modport eng (input req, input wr, input addr, input wdata, output done, output rdata);
endinterface

// file: src/flash_bus_cycle.sv
// One asynchronous flash bus cycle: a write strobe or an OE read.
`timescale 1ns/1ns
module flash_bus_cycle (
	input  wire logic                             mclk,
	input  wire logic                             rst,
	flash_cycle_if.eng                            cyc,
	output logic                                  ce_n,
	output logic                                  oe_n,
	output logic                                  we_n,
	output logic [flash_host_pkg::ADDR_W-1:0]     addr,
	output logic [flash_host_pkg::DATA_W-1:0]     dq_o,
	output logic                                  dq_oe,
	input  wire logic [flash_host_pkg::DATA_W-1:0] dq_i
);
	// Strobe is held for the read cycle time, then released for the OE high time.
	localparam logic [3:0] STROBE_END = 4'(flash_host_pkg::RC_CYC);
	localparam logic [3:0] IDLE_END = 4'(flash_host_pkg::RC_CYC + flash_host_pkg::OEHP_CYC);
	logic [3:0] cnt_q, cnt_d;
	logic busy_q, busy_d, wr_q, wr_d;
	logic [flash_host_pkg::ADDR_W-1:0] addr_q, addr_d;
	logic [flash_host_pkg::DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
	logic [flash_host_pkg::DATA_W-1:0] s1_q, s2_q, s3_q;

	always_comb
	begin
		busy_d = busy_q;
		cnt_d = cnt_q;
		wr_d = wr_q;
		addr_d = addr_q;
		wd_d = wd_q;
		rd_d = rd_q;
		if (!busy_q && cyc.req)
		begin
			busy_d = 1'b1;
			cnt_d = 4'h0;
			wr_d = cyc.wr;
			addr_d = cyc.addr;
			wd_d = cyc.wdata;
		end
		else if (busy_q)
		begin
			cnt_d = cnt_q + 4'h1;
			// Data counts only once the last two sampling stages agree.
			if (cnt_q == STROBE_END && s2_q == s3_q)
				rd_d = s3_q;
			if (cnt_q == IDLE_END)
				busy_d = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			busy_q <= 1'b0;
			cnt_q <= 4'h0;
			wr_q <= 1'b0;
			addr_q <= '0;
			wd_q <= '0;
			rd_q <= '0;
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end
		else
		begin
			busy_q <= busy_d;
			cnt_q <= cnt_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wd_q <= wd_d;
			rd_q <= rd_d;
			// Data is sampled with three stages; the strobe is long enough to settle.
			s1_q <= dq_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	wire strobe = busy_q && cnt_q > 4'h0 && cnt_q <= STROBE_END;
	assign ce_n = !strobe;
	assign we_n = !(strobe && wr_q);
	// OE stays high while WE and CE are low together.
	assign oe_n = !(strobe && !wr_q);
	assign dq_o = wd_q;
	assign dq_oe = busy_q && wr_q;
	assign addr = addr_q;
	assign cyc.rdata = rd_q;
	assign cyc.done = busy_q && cnt_q == IDLE_END;

	property p_oe_high_on_write;
		@(posedge mclk) disable iff (rst) (!we_n && !ce_n) |-> oe_n;
	endproperty
	a_oe_high_on_write: assert property (p_oe_high_on_write) else $error("OE low during write");
endmodule

// file: sim/flash_model.sv
// Behavioural NOR flash that answers the host controller's bus cycles.
`timescale 1ns/1ns
module flash_model #(
	parameter int          CHIP_CYC  = 3200,
	parameter int          SMALL_CYC = 400,
	parameter int          LARGE_CYC = 1200,
	parameter int          ERES_CYC  = 50,
	parameter logic [15:0] MFR_CODE  = 16'h0000,
	parameter logic [15:0] DEV_CODE  = 16'h0000,
	parameter logic [15:0] ADD_CODE  = 16'h0000
) (
	input  wire logic        mclk,
	input  wire logic        ce_n,
	input  wire logic        oe_n,
	input  wire logic        we_n,
	input  wire logic [19:0] addr,
	input  wire logic [15:0] dq_o,
	input  wire logic        dq_oe,
	input  wire logic        byte_mode,
	input  wire logic        stall,
	output logic      [15:0] dq_i
);
	localparam logic [15:0] QRY [37] = '{
		16'h0051, 16'h0052, 16'h0059, 16'h0002, 16'h0000, 16'h0041, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0027, 16'h0036, 16'h0000, 16'h0000, 16'h0004,
		16'h0000, 16'h0009, 16'h000e, 16'h0004, 16'h0000, 16'h0004, 16'h0004, 16'h0015,
		16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0002, 16'h0007, 16'h0000, 16'h0020,
		16'h0000, 16'h001e, 16'h0000, 16'h0000, 16'h0001};
	// Power-up always lands in array read mode.
	logic [1:0]  mode = 2'h0;
	logic [7:0]  h1 = 8'h00, h2 = 8'h00, h3 = 8'h00, cd = 8'h00, last_d = 8'h00;
	logic [19:0] ca = 20'h00000, poll_a = 20'h00000, last_a = 20'h00000, wa;
	logic [15:0] rd, last_q = 16'h0000;
	logic        wr_q = 1'b0, rd_q = 1'b0, tog = 1'b0, susp = 1'b0, poll_v = 1'b0;
	int          busy_cnt = 0, oe_err = 0, addr_err = 0, sus_err = 0, since_res = 1000, drv_err = 0;

	always_comb
	begin
		wa = byte_mode ? {1'b0, addr[19:1]} : addr;
		rd = addr[15:0] ^ 16'h5a5a;
		if (busy_cnt != 0)
			rd = {9'h000, tog, 6'h00};
		else if (mode == 2'h1)
			rd = (addr == 20'h00000) ? MFR_CODE : (addr == 20'h00001) ? DEV_CODE :
				(addr == 20'h00003) ? ADD_CODE : 16'h0000;
		else if (mode == 2'h2)
			rd = (wa >= 20'h10 && wa <= 20'h34) ? QRY[wa - 20'h10] : 16'h0000;
	end

	// A released bus shows the inverse of the last word, so a stale sample cannot pass.
	assign dq_i = (!ce_n && !oe_n) ? rd : ~last_q;

	always @(posedge mclk)
	begin
		if (!ce_n && !we_n && !oe_n)
			oe_err <= oe_err + 1;
		// The host must drive data through a write and release it before any read.
		if ((!ce_n && !we_n && !dq_oe) || (!oe_n && dq_oe))
			drv_err <= drv_err + 1;
		if (!ce_n && !oe_n)
			last_q <= rd;
		if (!ce_n && !we_n)
		begin
			ca <= addr;
			cd <= dq_o[7:0];
		end
		since_res <= (since_res < ERES_CYC) ? since_res + 1 : since_res;
		if (busy_cnt != 0 && !susp && !stall)
			busy_cnt <= busy_cnt - 1;
		if (!ce_n && !oe_n && !rd_q && busy_cnt != 0)
		begin
			tog <= ~tog;
			poll_a <= addr;
			poll_v <= 1'b1;
			if (poll_v && addr != poll_a)
				addr_err <= addr_err + 1;
		end
		if (wr_q && (ce_n || we_n))
		begin
			h1 <= cd;
			h2 <= h1;
			h3 <= h2;
			last_a <= ca;
			last_d <= cd;
			if (cd == 8'hf0)
				mode <= 2'h0;
			else if (cd == 8'h90 && ca[11:0] == 12'h555)
				mode <= 2'h1;
			else if (cd == 8'h98 && ca[11:0] == 12'h055)
				mode <= 2'h2;
			else if (cd == 8'hb0)
			begin
				susp <= 1'b1;
				if (since_res < ERES_CYC)
					sus_err <= sus_err + 1;
			end
			else if (cd == 8'hd0)
			begin
				susp <= 1'b0;
				since_res <= 0;
			end
			else if (h1 == 8'h55 && h2 == 8'haa && h3 == 8'h80 &&
				(cd == 8'h30 || (cd == 8'h10 && ca[11:0] == 12'h555)))
			begin
				busy_cnt <= (cd == 8'h10) ? CHIP_CYC : (ca < 20'h08000) ? SMALL_CYC : LARGE_CYC;
				tog <= 1'($urandom);
				poll_v <= 1'b0;
			end
		end
		wr_q <= !ce_n && !we_n;
		rd_q <= !ce_n && !oe_n;
	end
endmodule

// file: sim/test_flash_host.sv
// Self-checking bench for the flash host controller against a flash model.
`timescale 1ns/1ns
module test_flash_host;
	typedef struct {logic [15:0] d; logic chk; logic tmo;} note_t;
	// Identification values are arbitrary.
	localparam logic [15:0] MFR = 16'h00a5, DEV = 16'h0b37, ADD = 16'h0c4e;
	// Erase runs at 200 cycles per device second, at the longest figures.
	localparam int CHIP = 3200, SMALL = 400, LARGE = 1200;
	localparam logic [7:0] QA [19] = '{8'h10, 8'h11, 8'h12, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26,
		8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34};
	localparam logic [15:0] QD [19] = '{16'h0051, 16'h0052, 16'h0059, 16'h0009, 16'h000e,
		16'h0004, 16'h0004, 16'h0004, 16'h0000, 16'h0000, 16'h0002, 16'h0007, 16'h0000,
		16'h0020, 16'h0000, 16'h001e, 16'h0000, 16'h0000, 16'h0001};
	logic                mclk = 1'b0, rst = 1'b1, op_valid = 1'b0, byte_mode = 1'b0, stall = 1'b0;
	logic [19:0]         op_addr = 20'h00000, ra, flash_addr;
	flash_host_pkg::op_t op_code = flash_host_pkg::OP_READ;
	logic                op_ready, res_valid, res_timeout, ce_n, oe_n, we_n, dq_oe;
	logic [15:0]         res_data, dq_o, dq_i;
	note_t               notes[$], cur;
	int                  num_errors = 0, samples_checked = 0, lat, wt;

	always #5 mclk = ~mclk;

	flash_host #(.TIMEOUT_CYC(5000), .ERES_CYC(50), .SUSP_CYC(20)) dut (.mclk(mclk), .rst(rst),
		.op_valid(op_valid), .op_ready(op_ready), .op_code(op_code), .op_addr(op_addr),
		.byte_mode(byte_mode), .res_valid(res_valid), .res_data(res_data),
		.res_timeout(res_timeout), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
		.flash_addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i));
	flash_model #(.CHIP_CYC(CHIP), .SMALL_CYC(SMALL), .LARGE_CYC(LARGE), .ERES_CYC(50),
		.MFR_CODE(MFR), .DEV_CODE(DEV), .ADD_CODE(ADD)) fm (.mclk(mclk), .ce_n(ce_n),
		.oe_n(oe_n), .we_n(we_n), .addr(flash_addr), .dq_o(dq_o), .dq_oe(dq_oe),
		.byte_mode(byte_mode),
		.stall(stall), .dq_i(dq_i));

	task automatic cmp_word(input logic [19:0] got, input logic [19:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: value %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_flag(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %0t: flag %b, expected %b", $time, got, exp);
		end
	endtask

	task automatic results();
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Requests change just after a rising edge and drop after the accepting edge.
	task automatic run_op(input flash_host_pkg::op_t c, input logic [19:0] a, input logic bm,
		input logic [15:0] d, input logic chk, input logic tmo);
		note_t n;
		n = '{d, chk, tmo};
		op_code <= c;
		op_addr <= a;
		byte_mode <= bm;
		op_valid <= 1'b1;
		wt = 0;
		@(negedge mclk);
		while (op_ready !== 1'b1 && wt < 200)
		begin
			@(negedge mclk);
			wt++;
		end
		notes.push_back(n);
		@(posedge mclk);
		op_valid <= 1'b0;
		lat = 0;
		while (res_valid !== 1'b1 && lat < 12000)
		begin
			@(negedge mclk);
			lat++;
		end
		@(posedge mclk);
	endtask

	task automatic qry(input logic [7:0] a, input logic bm, input logic [15:0] d);
		run_op(flash_host_pkg::OP_QUERY_READ, {12'h000, a}, bm, d, 1'b1, 1'b0);
	endtask

	task automatic erase(input flash_host_pkg::op_t c, input logic [19:0] a,
		input logic [19:0] m, input logic [7:0] d, input int cyc);
		run_op(c, a, 1'b0, 16'h0000, 1'b0, 1'b0);
		cmp_word({12'h000, fm.last_d}, {12'h000, d});
		cmp_word(fm.last_a & m, a & m);
		cmp_flag(fm.busy_cnt == 0 && lat >= cyc, 1'b1);
	endtask

	// Results are looked at mid-cycle, away from the edge that launches them.
	always @(negedge mclk)
	begin
		if (res_valid === 1'b1)
		begin
			if (notes.size() == 0)
				cmp_flag(1'b1, 1'b0);
			else
			begin
				cur = notes.pop_front();
				if (cur.chk)
					cmp_word({4'h0, res_data}, {4'h0, cur.d});
				cmp_flag(res_timeout, cur.tmo);
			end
		end
	end

	initial
	begin
		#400000;
		num_errors++;
		$display("ERROR %0t: watchdog expired", $time);
		results();
	end

	initial
	begin
		void'($urandom(83));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		run_op(flash_host_pkg::OP_READ, 20'h00000, 1'b0, 16'h5a5a, 1'b1, 1'b0);
		run_op(flash_host_pkg::OP_ID_READ, 20'h00000, 1'b0, MFR, 1'b1, 1'b0);
		run_op(flash_host_pkg::OP_ID_READ, 20'h00001, 1'b0, DEV, 1'b1, 1'b0);
		run_op(flash_host_pkg::OP_ID_READ, 20'h00003, 1'b0, ADD, 1'b1, 1'b0);
		run_op(flash_host_pkg::OP_READ, 20'h00001, 1'b0, 16'h5a5b, 1'b1, 1'b0);
		for (int i = 0; i < 19; i++)
			qry(QA[i], 1'b0, QD[i]);
		qry(8'h10, 1'b1, 16'h0051);
		qry(8'h26, 1'b1, 16'h0004);
		repeat (4)
		begin
			ra = 20'($urandom);
			run_op(flash_host_pkg::OP_READ, ra, 1'($urandom), ra[15:0] ^ 16'h5a5a, 1'b1, 1'b0);
		end
		erase(flash_host_pkg::OP_CHIP_ERASE, 20'h00555, 20'h00fff, 8'h10, CHIP);
		erase(flash_host_pkg::OP_SECTOR_ERASE, 20'h03000, 20'hfffff, 8'h30, SMALL);
		erase(flash_host_pkg::OP_SECTOR_ERASE, 20'hf8000, 20'hfffff, 8'h30, LARGE);
		stall <= 1'b1;
		run_op(flash_host_pkg::OP_SECTOR_ERASE, 20'h01000, 1'b0, 16'h0000, 1'b0, 1'b1);
		stall <= 1'b0;
		wt = 0;
		while (fm.busy_cnt != 0 && wt < 2000)
		begin
			@(posedge mclk);
			wt++;
		end
		run_op(flash_host_pkg::OP_RESUME, 20'h00000, 1'b0, 16'h0000, 1'b0, 1'b0);
		run_op(flash_host_pkg::OP_SUSPEND, 20'h00000, 1'b0, 16'h0000, 1'b0, 1'b0);
		cmp_flag(lat >= 20 && lat <= 60 && fm.last_d == 8'hb0, 1'b1);
		cmp_word(20'(fm.sus_err), 20'h00000);
		cmp_word(20'(fm.oe_err), 20'h00000);
		cmp_word(20'(fm.drv_err), 20'h00000);
		cmp_word(20'(fm.addr_err), 20'h00000);
		cmp_flag(notes.size() == 0, 1'b1);
		results();
	end
endmodule
